// file: irq_wake_ctrl.sv
// Multi-function interrupt, wake-up and power-down controller with APB registers
//
// How it works
// - Low supply sets flag; vector needs all enables
// - Low-voltage service clears global and group flag
// - Timers have P/A flags; enhanced adds B
// - Comparator matches set timer flags
// - Timer vector needs global, source, group enables
// - Timer service clears global and group only
// - Any rising flag wakes, enables ignored
// - Flag high before halt gives no wake
// - Flags stay set until serviced or cleared
// - Entry pushes only the program counter
// - Return-from-irq sets global; plain return doesn't
// - Only halt enters sleep, stopping clock
// - Sleep freezes memory, registers and ports
// - Halt clears watchdog; runs only on subclock
// - Halt sets power-down, clears time-out flag
// - Wake on reset, port edge, flag, watchdog
// - Reset wake resets all; watchdog wake partial
// - Power-down flag cleared by power-up, clear-watchdog
// - Watchdog time-out sets flag, resets PC/SP only
// - Enabled port pin falling edge resumes after halt
// - Disabled or stack-full wake resumes, services later
// - Enabled wake with stack room takes vector
//
// The APB register port and the address map were chosen for this implementation.
module irq_wake_ctrl
   import irq_wake_pkg::*;
#(
   parameter int               NUM_TMR  = 3,
   parameter logic [MAX_TMR-1:0] ENH_MASK = 5'h04,
   parameter int               PA_W     = 8
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire irq_wake_pkg::apb_req_t      apb,
   output logic [irq_wake_pkg::DATA_W-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        lowvolt_detect,
   input  wire irq_wake_pkg::tmr_match_t [NUM_TMR-1:0] tmr_match,
   input  wire logic [PA_W-1:0]             porta_pins,
   input  wire logic                        ext_reset_req,
   input  wire logic                        wdt_overflow,
   input  wire irq_wake_pkg::core_ops_t     core_ops,
   output logic                             irq_call,
   output logic [irq_wake_pkg::VEC_W-1:0]   irq_vector,
   output logic                             pc_push,
   output logic                             core_hold,
   output logic                             sys_clk_enable,
   output logic                             wdt_clear,
   output logic                             wdt_run,
   output logic                             sys_reset_pulse,
   output logic                             wdt_reset_pulse,
   output logic                             wake_resume
);
   import irq_wake_pkg::*;

   localparam int NUM_MF = NUM_TMR + 1;

   // Refuse sizes the flag image and vector field cannot hold
   if (NUM_TMR < 1 || NUM_TMR > MAX_TMR) begin : g_bad_tmr
      $error("NUM_TMR out of range");
   end
   if (PA_W < 1 || PA_W > MAX_PA) begin : g_bad_pa
      $error("PA_W out of range");
   end

   // Lowest pending group wins the vector
   function automatic logic [VEC_W-1:0] first_set(input logic [NUM_MF-1:0] v);
      logic [VEC_W-1:0] idx;
      idx = '0;
      for (int i = NUM_MF - 1; i >= 0; i--) begin
         if (v[i])
            idx = VEC_W'(i);
      end
      return idx;
   endfunction : first_set

   function automatic logic reg_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : reg_is

   pwr_state_t            state;
   logic                  global_irq_enable;
   logic                  lowvolt_irq_enable;
   logic [NUM_MF-1:0]     multifunc_irq_enable;
   logic [NUM_MF-1:0]     multifunc_req_flags;
   logic                  lowvolt_req_flag;
   logic [NUM_TMR-1:0]    tmr_period_match_flag;
   logic [NUM_TMR-1:0]    tmr_a_match_flag;
   logic [NUM_TMR-1:0]    tmr_b_match_flag;
   logic [NUM_TMR-1:0]    tmr_period_match_enable;
   logic [NUM_TMR-1:0]    tmr_a_match_enable;
   logic [NUM_TMR-1:0]    tmr_b_match_enable;
   logic                  powerdown_flag;
   logic                  watchdog_timeout_flag;
   logic [PA_W-1:0]       porta_wake_enable;
   logic                  wdt_enable;
   logic                  wdt_sub_clk;
   logic                  lowvolt_prev;
   logic [PA_W-1:0]       porta_prev;
   logic [NUM_MF-1:0]     group_cond_prev;
   logic [DATA_W-1:0]     flags_prev;

   logic                  wr_en;
   logic                  rd_setup;
   logic                  addr_hit;
   logic [DATA_W-1:0]     sw_clr;
   logic [DATA_W-1:0]     sw_set;
   logic [DATA_W-1:0]     flags_word;
   logic [DATA_W-1:0]     rd_word;
   logic [NUM_MF-1:0]     group_cond;
   logic [NUM_MF-1:0]     group_set;
   logic [NUM_MF-1:0]     pending;
   logic [NUM_MF-1:0]     svc_clr;
   logic                  take_irq;
   logic [VEC_W-1:0]      take_vec;
   logic                  asleep;
   logic                  flag_rise;
   logic                  porta_fall;
   logic                  irq_wake;

   // APB slave: zero wait states, read data captured in the setup cycle
   assign wr_en    = apb.psel & apb.penable & apb.pwrite;
   assign rd_setup = apb.psel & ~apb.penable & ~apb.pwrite;
   assign pready   = 1'b1;
   assign addr_hit = reg_is(apb.paddr, CTRL_OFS) | reg_is(apb.paddr, TMR_EN_OFS)
                   | reg_is(apb.paddr, FLAGS_OFS) | reg_is(apb.paddr, FLAG_SET_OFS)
                   | reg_is(apb.paddr, STATUS_OFS) | reg_is(apb.paddr, PAWAKE_OFS)
                   | reg_is(apb.paddr, WDT_CFG_OFS);
   // Unmapped offsets answer with an error rather than a wait
   assign pslverr  = apb.psel & apb.penable & ~addr_hit;

   assign sw_clr = (wr_en & reg_is(apb.paddr, FLAGS_OFS)) ? apb.pwdata : ZERO_WORD;
   assign sw_set = (wr_en & reg_is(apb.paddr, FLAG_SET_OFS)) ? apb.pwdata : ZERO_WORD;

   assign asleep         = (state == st_sleep);
   assign core_hold      = asleep;
   assign sys_clk_enable = ~asleep;
   // Watchdog on the system clock stops with it
   assign wdt_run        = wdt_enable & (wdt_sub_clk | ~asleep);

   // Flag image, also the reference for wake edge detection
   always_comb begin
      flags_word             = ZERO_WORD;
      flags_word[FLG_LV_BIT] = lowvolt_req_flag;
      for (int i = 0; i < NUM_TMR; i++) begin
         flags_word[FLG_TMR_LSB + TMR_FIELD_W*i + TMR_P_OFS] = tmr_period_match_flag[i];
         flags_word[FLG_TMR_LSB + TMR_FIELD_W*i + TMR_A_OFS] = tmr_a_match_flag[i];
         flags_word[FLG_TMR_LSB + TMR_FIELD_W*i + TMR_B_OFS] = tmr_b_match_flag[i];
      end
      for (int m = 0; m < NUM_MF; m++)
         flags_word[FLG_MF_LSB + m] = multifunc_req_flags[m];
   end

   // Low-voltage source flag: hardware set wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lowvolt_prev     <= 1'b0;
         lowvolt_req_flag <= 1'b0;
      end else begin
         lowvolt_prev     <= lowvolt_detect;
         lowvolt_req_flag <= (lowvolt_req_flag & ~sw_clr[FLG_LV_BIT])
                           | (lowvolt_detect & ~lowvolt_prev)
                           | sw_set[FLG_LV_BIT];
      end
   end

   // Timer source flags; B exists only on enhanced timers
   generate
      for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
         localparam int PB = FLG_TMR_LSB + TMR_FIELD_W*t + TMR_P_OFS;
         localparam int AB = FLG_TMR_LSB + TMR_FIELD_W*t + TMR_A_OFS;
         localparam int BB = FLG_TMR_LSB + TMR_FIELD_W*t + TMR_B_OFS;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tmr_period_match_flag[t] <= 1'b0;
               tmr_a_match_flag[t]      <= 1'b0;
               tmr_b_match_flag[t]      <= 1'b0;
            end else begin
               tmr_period_match_flag[t] <= (tmr_period_match_flag[t] & ~sw_clr[PB])
                                         | tmr_match[t].period | sw_set[PB];
               tmr_a_match_flag[t]      <= (tmr_a_match_flag[t] & ~sw_clr[AB])
                                         | tmr_match[t].a | sw_set[AB];
               tmr_b_match_flag[t]      <= ENH_MASK[t] & ((tmr_b_match_flag[t] & ~sw_clr[BB])
                                         | tmr_match[t].b | sw_set[BB]);
            end
         end
         assign group_cond[t+1] = (tmr_period_match_flag[t] & tmr_period_match_enable[t])
                                | (tmr_a_match_flag[t] & tmr_a_match_enable[t])
                                | (tmr_b_match_flag[t] & tmr_b_match_enable[t]);
      end
   endgenerate

   assign group_cond[0] = lowvolt_req_flag & lowvolt_irq_enable;
   // A source enabled late still raises its group, so a held request is served later
   assign group_set     = group_cond & ~group_cond_prev;

   assign pending  = multifunc_req_flags & multifunc_irq_enable;
   // No entry while halted or on the halt cycle itself
   assign take_irq = global_irq_enable & (|pending) & ~core_ops.stack_full
                   & ~asleep & ~core_ops.halt;
   // Group index doubles as the vector number
   assign take_vec = first_set(pending);
   assign svc_clr  = take_irq ? (NUM_MF'(1) << take_vec) : '0;

   // Group flags: only the serviced group clears, a fresh set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         group_cond_prev     <= '0;
         multifunc_req_flags <= '0;
      end else begin
         group_cond_prev     <= group_cond;
         multifunc_req_flags <= (multifunc_req_flags & ~svc_clr & ~sw_clr[FLG_MF_LSB +: NUM_MF])
                              | group_set | sw_set[FLG_MF_LSB +: NUM_MF];
      end
   end

   // Vectored entry: only the program counter is pushed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_call   <= 1'b0;
         pc_push    <= 1'b0;
         irq_vector <= '0;
      end else begin
         irq_call <= take_irq;
         pc_push  <= take_irq;
         if (take_irq)
            irq_vector <= take_vec;
      end
   end

   // Control and enable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_enable       <= 1'b0;
         lowvolt_irq_enable      <= 1'b0;
         multifunc_irq_enable    <= '0;
         tmr_period_match_enable <= '0;
         tmr_a_match_enable      <= '0;
         tmr_b_match_enable      <= '0;
         porta_wake_enable       <= '0;
         wdt_enable              <= 1'b0;
         wdt_sub_clk             <= 1'b0;
      end else begin
         if (take_irq)
            global_irq_enable <= 1'b0;
         else if (core_ops.return_from_irq_instr)
            global_irq_enable <= 1'b1;
         else if (wr_en && reg_is(apb.paddr, CTRL_OFS))
            global_irq_enable <= apb.pwdata[GIE_BIT];
         if (wr_en && reg_is(apb.paddr, CTRL_OFS)) begin
            lowvolt_irq_enable   <= apb.pwdata[LVE_BIT];
            multifunc_irq_enable <= apb.pwdata[MFE_LSB +: NUM_MF];
         end
         if (wr_en && reg_is(apb.paddr, TMR_EN_OFS)) begin
            for (int i = 0; i < NUM_TMR; i++) begin
               tmr_period_match_enable[i] <= apb.pwdata[TMR_FIELD_W*i + TMR_P_OFS];
               tmr_a_match_enable[i]      <= apb.pwdata[TMR_FIELD_W*i + TMR_A_OFS];
               tmr_b_match_enable[i]      <= apb.pwdata[TMR_FIELD_W*i + TMR_B_OFS] & ENH_MASK[i];
            end
         end
         if (wr_en && reg_is(apb.paddr, PAWAKE_OFS))
            porta_wake_enable <= apb.pwdata[PA_W-1:0];
         if (wr_en && reg_is(apb.paddr, WDT_CFG_OFS)) begin
            wdt_enable  <= apb.pwdata[WDT_EN_BIT];
            wdt_sub_clk <= apb.pwdata[WDT_SUB_BIT];
         end
      end
   end

   // Wake sources: a flag already high at halt has no edge to give
   assign flag_rise  = |(flags_word & ~flags_prev);
   assign porta_fall = |(porta_prev & ~porta_pins & porta_wake_enable);
   assign irq_wake   = asleep & (flag_rise | porta_fall);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_prev <= ZERO_WORD;
         porta_prev <= '0;
      end else begin
         flags_prev <= flags_word;
         porta_prev <= porta_pins;
      end
   end

   // Power state: halt is the only way in
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_run;
      end else begin
         case (state)
            st_run: begin
               if (core_ops.halt && !ext_reset_req && !wdt_overflow)
                  state <= st_sleep;
            end
            st_sleep: begin
               if (ext_reset_req || wdt_overflow || irq_wake)
                  state <= st_run;
            end
            default: state <= st_run;
         endcase
      end
   end

   // Halt and wake side effects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_clear       <= 1'b0;
         wake_resume     <= 1'b0;
         sys_reset_pulse <= 1'b0;
         wdt_reset_pulse <= 1'b0;
      end else begin
         wdt_clear       <= (~asleep & core_ops.halt) | core_ops.clr_wdt;
         // Resume after halt; any enabled request is then taken normally
         wake_resume     <= irq_wake & ~ext_reset_req & ~wdt_overflow;
         sys_reset_pulse <= ext_reset_req;
         wdt_reset_pulse <= wdt_overflow;
      end
   end

   // Status flags survive the partial watchdog reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         powerdown_flag        <= 1'b0;
         watchdog_timeout_flag <= 1'b0;
      end else begin
         if (~asleep && core_ops.halt)
            powerdown_flag <= 1'b1;
         else if (core_ops.clr_wdt)
            powerdown_flag <= 1'b0;
         if (wdt_overflow)
            watchdog_timeout_flag <= 1'b1;
         else if (~asleep && core_ops.halt)
            watchdog_timeout_flag <= 1'b0;
      end
   end

   always_comb begin
      rd_word = ZERO_WORD;
      if (reg_is(apb.paddr, CTRL_OFS)) begin
         rd_word[GIE_BIT]               = global_irq_enable;
         rd_word[LVE_BIT]               = lowvolt_irq_enable;
         rd_word[MFE_LSB +: NUM_MF]     = multifunc_irq_enable;
      end else if (reg_is(apb.paddr, TMR_EN_OFS)) begin
         for (int i = 0; i < NUM_TMR; i++) begin
            rd_word[TMR_FIELD_W*i + TMR_P_OFS] = tmr_period_match_enable[i];
            rd_word[TMR_FIELD_W*i + TMR_A_OFS] = tmr_a_match_enable[i];
            rd_word[TMR_FIELD_W*i + TMR_B_OFS] = tmr_b_match_enable[i];
         end
      end else if (reg_is(apb.paddr, FLAGS_OFS)) begin
         rd_word = flags_word;
      end else if (reg_is(apb.paddr, STATUS_OFS)) begin
         rd_word[ST_PDF_BIT]   = powerdown_flag;
         rd_word[ST_TO_BIT]    = watchdog_timeout_flag;
         rd_word[ST_SLEEP_BIT] = asleep;
      end else if (reg_is(apb.paddr, PAWAKE_OFS)) begin
         rd_word[PA_W-1:0] = porta_wake_enable;
      end else if (reg_is(apb.paddr, WDT_CFG_OFS)) begin
         rd_word[WDT_EN_BIT]  = wdt_enable;
         rd_word[WDT_SUB_BIT] = wdt_sub_clk;
      end
   end

   // Registered in setup so the word stands for the whole access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= ZERO_WORD;
      else if (rd_setup)
         prdata <= rd_word;
   end

endmodule : irq_wake_ctrl

// file: irq_wake_pkg.sv
// Shared constants and carrier types for the interrupt, wake-up and power-down controller
package irq_wake_pkg;

   localparam int          DATA_W       = 32;
   localparam int          ADDR_W       = 8;

   // Register byte offsets
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  TMR_EN_OFS   = 8'h04;
   localparam logic [7:0]  FLAGS_OFS    = 8'h08;
   localparam logic [7:0]  FLAG_SET_OFS = 8'h0C;
   localparam logic [7:0]  STATUS_OFS   = 8'h10;
   localparam logic [7:0]  PAWAKE_OFS   = 8'h14;
   localparam logic [7:0]  WDT_CFG_OFS  = 8'h18;

   // Control register fields
   localparam int          GIE_BIT      = 0;
   localparam int          LVE_BIT      = 1;
   localparam int          MFE_LSB      = 8;

   // Flag register fields (same layout for clear and set)
   localparam int          FLG_LV_BIT   = 0;
   localparam int          FLG_TMR_LSB  = 8;
   localparam int          FLG_MF_LSB   = 24;
   localparam int          TMR_FIELD_W  = 3;
   localparam int          TMR_P_OFS    = 0;
   localparam int          TMR_A_OFS    = 1;
   localparam int          TMR_B_OFS    = 2;

   // Status register fields
   localparam int          ST_PDF_BIT   = 0;
   localparam int          ST_TO_BIT    = 1;
   localparam int          ST_SLEEP_BIT = 2;

   // Watchdog configuration fields
   localparam int          WDT_EN_BIT   = 0;
   localparam int          WDT_SUB_BIT  = 1;

   localparam int          MAX_TMR      = 5;
   localparam int          MAX_MF       = 6;
   localparam int          MAX_PA       = 8;
   localparam int          VEC_W        = 3;

   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic period;
      logic a;
      logic b;
   } tmr_match_t;

   typedef struct packed {
      logic halt;
      logic return_from_irq_instr;
      logic ret;
      logic clr_wdt;
      logic stack_full;
   } core_ops_t;

   typedef enum logic {
      st_run,
      st_sleep
   } pwr_state_t;

endpackage : irq_wake_pkg

// file: irq_wake_ctrl_chk.sv
// Port assertions for the interrupt, wake-up and power-down controller
module irq_wake_ctrl_chk
   import irq_wake_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    ext_reset_req,
   input wire logic                    wdt_overflow,
   input wire irq_wake_pkg::core_ops_t core_ops,
   input wire logic                    irq_call,
   input wire logic                    pc_push,
   input wire logic                    core_hold,
   input wire logic                    sys_clk_enable,
   input wire logic                    wdt_clear,
   input wire logic                    sys_reset_pulse,
   input wire logic                    wdt_reset_pulse,
   input wire logic                    wake_resume
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_halt_awake;
      core_ops.halt && !core_hold;
   endsequence
   sequence s_asleep;
      core_hold && !sys_clk_enable && wdt_clear;
   endsequence

   chk_halt_sleeps: assert property (s_halt_awake |=> s_asleep)
      else $error("halt did not stop the clock and clear the watchdog");
   chk_clock_follows: assert property (sys_clk_enable == !core_hold)
      else $error("clock enable disagrees with sleep state");
   chk_push_with_call: assert property (irq_call == pc_push)
      else $error("program counter push not paired with call");
   chk_call_single: assert property (irq_call |=> !irq_call)
      else $error("second call before global enable restored");
   chk_no_call_asleep: assert property (core_hold |-> !irq_call)
      else $error("call issued while asleep");
   chk_stack_blocks: assert property (core_ops.stack_full |=> !irq_call)
      else $error("call issued with stack full");
   chk_ext_reset: assert property (ext_reset_req |=> sys_reset_pulse)
      else $error("external reset not passed on");
   chk_wdt_reset: assert property (wdt_overflow |=> wdt_reset_pulse)
      else $error("watchdog reset not passed on");
   chk_wake_awake: assert property (wake_resume |-> $fell(core_hold))
      else $error("resume pulse without leaving sleep");
endmodule : irq_wake_ctrl_chk

bind irq_wake_ctrl irq_wake_ctrl_chk irq_wake_ctrl_chk_inst (.pclk(pclk), .presetn(presetn),
   .ext_reset_req(ext_reset_req), .wdt_overflow(wdt_overflow), .core_ops(core_ops), .irq_call(irq_call),
   .pc_push(pc_push), .core_hold(core_hold), .sys_clk_enable(sys_clk_enable), .wdt_clear(wdt_clear),
   .sys_reset_pulse(sys_reset_pulse), .wdt_reset_pulse(wdt_reset_pulse), .wake_resume(wake_resume));

// file: test_irq_wake_ctrl.sv
// Self-checking testbench for the interrupt, wake-up and power-down controller
module test_irq_wake_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_wake_pkg::*;
   logic             pclk, presetn, lowvolt_detect, ext_reset_req, wdt_overflow, err;
   apb_req_t         apb;
   tmr_match_t [2:0] tmr_match;
   core_ops_t        core_ops;
   logic [7:0]       porta_pins;
   logic [31:0]      prdata, rd, v, seed;
   logic [2:0]       irq_vector;
   logic             pready, pslverr, irq_call, pc_push, core_hold, sys_clk_enable;
   logic             wdt_clear, wdt_run, sys_reset_pulse, wdt_reset_pulse, wake_resume;
   int               n_fail, checks_done;
   int               exp_vec[$];
   logic [7:0]       ofs [8] = '{CTRL_OFS, TMR_EN_OFS, FLAGS_OFS, FLAG_SET_OFS, STATUS_OFS,
                                 PAWAKE_OFS, WDT_CFG_OFS, 8'h1C};

   irq_wake_ctrl irq_wake_ctrl_inst (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lowvolt_detect(lowvolt_detect), .tmr_match(tmr_match),
      .porta_pins(porta_pins), .ext_reset_req(ext_reset_req), .wdt_overflow(wdt_overflow),
      .core_ops(core_ops), .irq_call(irq_call), .irq_vector(irq_vector), .pc_push(pc_push),
      .core_hold(core_hold), .sys_clk_enable(sys_clk_enable), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
      .sys_reset_pulse(sys_reset_pulse), .wdt_reset_pulse(wdt_reset_pulse), .wake_resume(wake_resume));

   always #2.5 pclk = ~pclk;

   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xorshift

   task automatic complete_run();
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic tick(int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   // Called just after a rising edge; holds the request until pready is sampled
   task automatic apb_xfer(logic wr, logic [7:0] addr, logic [31:0] wd);
      int i;
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge pclk);
      apb.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i == 50) begin
         n_fail++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      apb <= '0;
      // Idle edge so the next setup never overwrites the release
      @(posedge pclk);
   endtask : apb_xfer

   task automatic rd_chk(string name, logic [7:0] addr, logic [31:0] msk, logic [31:0] exp);
      apb_xfer(1'b0, addr, '0);
      check(name, exp & msk, rd & msk);
   endtask : rd_chk

   task automatic core_pulse(logic [4:0] m);
      core_ops <= core_ops_t'(m);
      @(posedge pclk);
      core_ops <= '0;
   endtask : core_pulse

   task automatic wait_hold(logic lvl);
      int i;
      for (i = 0; i < 20 && core_hold !== lvl; i++)
         @(posedge pclk);
      if (i == 20) begin
         n_fail++;
         complete_run();
      end
   endtask : wait_hold

   // Reference model of vectored entries: each call must match the oldest expected group
   always @(posedge pclk) begin
      if (presetn === 1'b1 && irq_call === 1'b1) begin
         if (exp_vec.size() == 0)
            check("unexpected irq_call", 32'h0, 32'h1);
         else
            check("irq_vector", 32'(exp_vec.pop_front()), 32'(irq_vector));
      end
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      apb = '0;
      lowvolt_detect = 1'b0;
      tmr_match = '0;
      porta_pins = 8'hFF;
      ext_reset_req = 1'b0;
      wdt_overflow = 1'b0;
      core_ops = '0;
      seed = 32'h0000_0027;
      tick(12);
      presetn <= 1'b1;
      tick(1);
      foreach (ofs[i])
         rd_chk("reset value", ofs[i], '1, 32'h0);
      check("pslverr unmapped", 32'h1, 32'(err));
      v = xorshift();
      apb_xfer(1'b1, CTRL_OFS, v & ~32'h1);
      rd_chk("ctrl", CTRL_OFS, 32'h0F03, v & 32'h0F02);
      v = xorshift();
      apb_xfer(1'b1, TMR_EN_OFS, v);
      rd_chk("tmr_en", TMR_EN_OFS, 32'h1FF, v & 32'h1DB);
      for (int t = 0; t < 3; t++) begin
         for (int k = 0; k < 3; k++) begin
            tmr_match[t] <= tmr_match_t'(3'b100 >> k);
            tick(1);
            tmr_match <= '0;
            tick(2);
            v = (t == 2 || k < 2) ? 32'h1 << (FLG_TMR_LSB + 3 * t + k) : 32'h0;
            rd_chk("timer flag", FLAGS_OFS, 32'h0001_FF00, v);
            apb_xfer(1'b1, FLAGS_OFS, 32'hFFFF_FFFF);
         end
      end
      apb_xfer(1'b1, TMR_EN_OFS, 32'h1FF);
      apb_xfer(1'b1, CTRL_OFS, 32'h0F03);
      exp_vec.push_back(2);
      tmr_match[1] <= tmr_match_t'(3'b010);
      tick(1);
      tmr_match <= '0;
      tick(6);
      check("pending calls", 32'h0, 32'(exp_vec.size()));
      rd_chk("ctrl after entry", CTRL_OFS, 32'h1, 32'h0);
      rd_chk("flags after entry", FLAGS_OFS, 32'hFF01_FF01, 32'h1000);
      core_pulse(5'h08);
      rd_chk("ctrl after return_from_irq_instr", CTRL_OFS, 32'h1, 32'h1);
      apb_xfer(1'b1, FLAGS_OFS, 32'hFFFF_FFFF);
      core_ops.stack_full <= 1'b1;
      lowvolt_detect <= 1'b1;
      tick(6);
      exp_vec.push_back(0);
      core_ops.stack_full <= 1'b0;
      tick(6);
      check("pending calls", 32'h0, 32'(exp_vec.size()));
      rd_chk("lowvolt flag kept", FLAGS_OFS, 32'h0100_0001, 32'h1);
      core_pulse(5'h04);
      rd_chk("ctrl after ret", CTRL_OFS, 32'h1, 32'h0);
      apb_xfer(1'b1, WDT_CFG_OFS, 32'h1);
      apb_xfer(1'b1, PAWAKE_OFS, 32'h1);
      core_pulse(5'h10);
      tick(1);
      check("wdt_run asleep", 32'h0, 32'(wdt_run));
      rd_chk("status asleep", STATUS_OFS, 32'h7, 32'h5);
      tmr_match[0] <= tmr_match_t'(3'b100);
      tick(1);
      tmr_match <= '0;
      wait_hold(1'b0);
      apb_xfer(1'b1, WDT_CFG_OFS, 32'h3);
      core_pulse(5'h10);
      tick(1);
      check("wdt_run subclock", 32'h1, 32'(wdt_run));
      tmr_match[0] <= tmr_match_t'(3'b100);
      tick(1);
      tmr_match <= '0;
      tick(8);
      check("flag high at halt", 32'h1, 32'(core_hold));
      porta_pins <= 8'hFE;
      wait_hold(1'b0);
      porta_pins <= 8'hFF;
      core_pulse(5'h10);
      tick(1);
      wdt_overflow <= 1'b1;
      tick(1);
      wdt_overflow <= 1'b0;
      wait_hold(1'b0);
      rd_chk("timeout flag", STATUS_OFS, 32'h2, 32'h2);
      core_pulse(5'h10);
      tick(1);
      rd_chk("status halt", STATUS_OFS, 32'h7, 32'h5);
      ext_reset_req <= 1'b1;
      tick(1);
      ext_reset_req <= 1'b0;
      wait_hold(1'b0);
      core_pulse(5'h02);
      rd_chk("powerdown cleared", STATUS_OFS, 32'h1, 32'h0);
      complete_run();
   end
endmodule : test_irq_wake_ctrl
